// ===== hdl/sac_regs.vh
`ifndef SAC_REGS_VH
`define SAC_REGS_VH

// ****************************************************************
// Clock and rounding
// ****************************************************************
`define SAC_CLK_PERIOD_NS      4
`define SAC_CEIL_CYC(ns)       (((ns) + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)

// ****************************************************************
// Pin timing in ns, fast grade
// ****************************************************************
`define SAC_FAST_CYCLE_NS      45
`define SAC_FAST_ACCESS_NS     45
`define SAC_FAST_PULSE_NS      35
`define SAC_FAST_HIZ_NS        18

// ****************************************************************
// Pin timing in ns, slow grade
// ****************************************************************
`define SAC_SLOW_CYCLE_NS      55
`define SAC_SLOW_ACCESS_NS     55
`define SAC_SLOW_PULSE_NS      40
`define SAC_SLOW_HIZ_NS        20

// ****************************************************************
// Pin timing in ns, both grades
// ****************************************************************
`define SAC_DATA_SETUP_NS      25
`define SAC_DATA_HOLD_NS       0
`define SAC_ADDR_HOLD_NS       0
`define SAC_ADDR_SETUP_NS      0
`define SAC_OUT_HOLD_NS        10
`define SAC_RETENTION_NS       0

// ****************************************************************
// Cycle counts
// ****************************************************************
`define SAC_FAST_CYCLE_CYC     `SAC_CEIL_CYC(`SAC_FAST_CYCLE_NS)
`define SAC_FAST_ACCESS_CYC    `SAC_CEIL_CYC(`SAC_FAST_ACCESS_NS)
`define SAC_FAST_PULSE_CYC     `SAC_CEIL_CYC(`SAC_FAST_PULSE_NS)
`define SAC_FAST_HIZ_CYC       `SAC_CEIL_CYC(`SAC_FAST_HIZ_NS)
`define SAC_SLOW_CYCLE_CYC     `SAC_CEIL_CYC(`SAC_SLOW_CYCLE_NS)
`define SAC_SLOW_ACCESS_CYC    `SAC_CEIL_CYC(`SAC_SLOW_ACCESS_NS)
`define SAC_SLOW_PULSE_CYC     `SAC_CEIL_CYC(`SAC_SLOW_PULSE_NS)
`define SAC_SLOW_HIZ_CYC       `SAC_CEIL_CYC(`SAC_SLOW_HIZ_NS)
`define SAC_SYNC_CYC           2

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define SAC_ADDR_W             18
`define SAC_DATA_W             16
`define SAC_CNT_W              8
`define SAC_ADDR_RST           18'h0_0000
`define SAC_DATA_RST           16'h0000

`endif

// ===== hdl/sac_timer.v
`timescale 1ns/10ps

// ****************************************************************
// Down counter, done while it stands at zero
// ****************************************************************
module sac_timer
(
  input  wire       ref_clk_i,
  input  wire       rst_n_i,
  input  wire       load_i,
  input  wire [7:0] load_val_i,
  output wire       done_o
);

  reg  [7:0] cnt_ff;
  reg  [7:0] nxt_cnt;

  always @*
  begin
    nxt_cnt = cnt_ff;
    if (load_i)
    begin
      nxt_cnt = load_val_i;
    end
    else if (cnt_ff != 8'h00)
    begin
      nxt_cnt = cnt_ff - 8'h01;
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_ff <= 8'h00;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign done_o = (cnt_ff == 8'h00);

endmodule

// ===== hdl/sac_ctrl.v
`timescale 1ns/10ps
`include "sac_regs.vh"

// Overview of operation
// R1: Write only while select, strobe, lane low
// R2: Data timed to first write-ending edge
// R3: Data valid 25 ns before, 0 after
// R4: Address settled 35/40 ns before write end
// R5: Address held past write-ending edge
// R6: Address settled before write strobe falls
// R7: Lanes and strobe low 35/40 ns
// R8: Memory data valid 45/55 ns after address
// R9: Memory holds old data 10 ns
// R10: Data valid 45/55 ns after select
// R11: Data valid 22/25 ns after gate
// R12: Lane data valid 45/55 ns after enable
// R13: Lane releases bus within 18/20 ns
// R14: Power-down within 45/55 ns after deselect
// R15: Deselected if select high or lanes high
// R16: Lanes steady while select is high
// R17: Retention allowed once deselected
// R18: Write strobe high throughout reads
// R19: Never drive bus while memory outputs
// R20: Accesses spaced one cycle time apart
// R21: Delays rounded up; read sampled late

module sac_ctrl
#(
  parameter SLOW_GRADE = 0
)
(
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  input  wire        req_i,
  input  wire        req_write_i,
  input  wire [17:0] req_addr_i,
  input  wire [15:0] req_wdata_i,
  input  wire [1:0]  req_lanes_i,
  output wire        ready_o,
  output wire        rvalid_o,
  output wire [15:0] rdata_o,
  output wire        deselected_o,
  output wire [17:0] sram_addr_o,
  output wire        sram_ce_n_o,
  output wire        sram_we_n_o,
  output wire        sram_oe_n_o,
  output wire        upper_lane_enable_n_o,
  output wire        lower_lane_enable_n_o,
  output wire [15:0] sram_dq_o,
  output wire        sram_dq_oe_o,
  input  wire [15:0] sram_dq_i
);

  // ****************************************************************
  // Grade dependent counts and synchroniser depth
  // ****************************************************************
  localparam integer CYCLE_NUM  = SLOW_GRADE ? `SAC_SLOW_CYCLE_CYC :
                                               `SAC_FAST_CYCLE_CYC;
  localparam integer ACCESS_NUM = SLOW_GRADE ? `SAC_SLOW_ACCESS_CYC :
                                               `SAC_FAST_ACCESS_CYC;
  localparam integer PULSE_NUM  = SLOW_GRADE ? `SAC_SLOW_PULSE_CYC :
                                               `SAC_FAST_PULSE_CYC;
  localparam integer HIZ_NUM    = SLOW_GRADE ? `SAC_SLOW_HIZ_CYC :
                                               `SAC_FAST_HIZ_CYC;
  localparam integer SYNC_NUM   = `SAC_SYNC_CYC;

  // Counts cut to the timer width; every one fits in eight bits
  localparam [7:0]   CYCLE_CYC  = CYCLE_NUM[7:0];
  localparam [7:0]   ACCESS_CYC = ACCESS_NUM[7:0];
  localparam [7:0]   PULSE_CYC  = PULSE_NUM[7:0];
  localparam [7:0]   HIZ_CYC    = HIZ_NUM[7:0];
  localparam [7:0]   SYNC_CYC   = SYNC_NUM[7:0];

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] ST_IDLE    = 3'h0;
  localparam [2:0] ST_W_SETUP = 3'h1;
  localparam [2:0] ST_W_PULSE = 3'h2;
  localparam [2:0] ST_W_END   = 3'h3;
  localparam [2:0] ST_R_WAIT  = 3'h4;
  localparam [2:0] ST_RECOV   = 3'h5;

  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [7:0]  cyc_ff;
  reg  [7:0]  nxt_cyc;
  reg         ready_ff;
  reg         nxt_ready;
  reg         rvalid_ff;
  reg         nxt_rvalid;
  reg  [15:0] rdata_ff;
  reg  [15:0] nxt_rdata;
  reg  [17:0] addr_ff;
  reg  [17:0] nxt_addr;
  reg         ce_n_ff;
  reg         nxt_ce_n;
  reg         we_n_ff;
  reg         nxt_we_n;
  reg         oe_n_ff;
  reg         nxt_oe_n;
  reg  [1:0]  lane_n_ff;
  reg  [1:0]  nxt_lane_n;
  reg  [15:0] dq_ff;
  reg  [15:0] nxt_dq;
  reg         dq_oe_ff;
  reg         nxt_dq_oe;
  reg  [15:0] dq_meta_ff;
  reg  [15:0] dq_sync_ff;
  reg         tmr_load;
  reg  [7:0]  tmr_val;
  wire        tmr_done;
  reg         desel_ff;
  reg         nxt_desel;

  // ****************************************************************
  // Read data synchroniser
  // ****************************************************************
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      dq_meta_ff <= `SAC_DATA_RST;
      dq_sync_ff <= `SAC_DATA_RST;
    end
    else
    begin
      dq_meta_ff <= sram_dq_i;
      dq_sync_ff <= dq_meta_ff;
    end
  end

  sac_timer u_timer
  (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (tmr_load),
    .load_val_i (tmr_val),
    .done_o     (tmr_done)
  );

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  always @*
  begin
    nxt_state  = state_ff;
    nxt_cyc    = cyc_ff + 8'h01;
    nxt_ready  = 1'b0;
    nxt_rvalid = 1'b0;
    nxt_rdata  = rdata_ff;
    nxt_addr   = addr_ff;
    nxt_ce_n   = ce_n_ff;
    nxt_we_n   = we_n_ff;
    nxt_oe_n   = oe_n_ff;
    nxt_lane_n = lane_n_ff;
    nxt_dq     = dq_ff;
    nxt_dq_oe  = dq_oe_ff;
    tmr_load   = 1'b0;
    tmr_val    = 8'h00;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_cyc   = 8'h00;
        nxt_ready = 1'b1;
        if (req_i && ready_ff)
        begin
          nxt_ready  = 1'b0;
          // Address settles with select, before the strobe falls
          nxt_addr   = req_addr_i;                   // [R6]
          nxt_ce_n   = 1'b0;
          nxt_lane_n = ~req_lanes_i;
          if (req_write_i)
          begin
            nxt_state = ST_W_SETUP;
            nxt_oe_n  = 1'b1;
            nxt_dq    = req_wdata_i;                 // [R3]
            nxt_dq_oe = 1'b1;                        // [R19]
          end
          else
          begin
            nxt_state = ST_R_WAIT;
            nxt_we_n  = 1'b1;                        // [R18]
            nxt_oe_n  = 1'b0;
            tmr_load  = 1'b1;
            // Wait worst-case access plus synchroniser depth
            tmr_val   = ACCESS_CYC + SYNC_CYC - 8'h01; // [R8] [R10] [R11] [R12] [R21]
          end
        end
      end
      ST_W_SETUP:
      begin
        // Strobe falls; select, strobe and any requested lane now overlap
        nxt_state = ST_W_PULSE;
        nxt_we_n  = 1'b0;                            // [R1]
        tmr_load  = 1'b1;
        tmr_val   = PULSE_CYC - 8'h01;               // [R7] [R4] [R21]
      end
      ST_W_PULSE:
      begin
        if (tmr_done)
        begin
          // Strobe rises first, so it is the write-ending edge
          nxt_state = ST_W_END;
          nxt_we_n  = 1'b1;                          // [R1] [R2]
        end
      end
      ST_W_END:
      begin
        // Address and data stay one cycle past the write end
        nxt_state  = ST_RECOV;
        nxt_ce_n   = 1'b1;                           // [R5] [R3]
        nxt_lane_n = 2'b11;                          // [R16]
        nxt_dq_oe  = 1'b0;
      end
      ST_R_WAIT:
      begin
        if (tmr_done)
        begin
          nxt_state  = ST_RECOV;
          nxt_rdata  = dq_sync_ff;                   // [R21]
          nxt_rvalid = 1'b1;
          nxt_ce_n   = 1'b1;
          nxt_oe_n   = 1'b1;
          nxt_lane_n = 2'b11;                        // [R16] [R15]
          tmr_load   = 1'b1;
          // Bus turnaround before anyone drives again
          tmr_val    = HIZ_CYC;                      // [R13] [R19]
        end
      end
      ST_RECOV:
      begin
        if (tmr_done && (cyc_ff >= CYCLE_CYC - 8'h01))
        begin
          nxt_state = ST_IDLE;                       // [R20] [R14] [R17]
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Deselect flag
  // ****************************************************************
  always @*
  begin
    // Both lanes high deselects the memory just as a high select does
    nxt_desel = nxt_ce_n | (&nxt_lane_n);            // [R15] [R17]
  end

  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_ff  <= ST_IDLE;
      cyc_ff    <= 8'h00;
      ready_ff  <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff  <= `SAC_DATA_RST;
      addr_ff   <= `SAC_ADDR_RST;
      ce_n_ff   <= 1'b1;
      we_n_ff   <= 1'b1;
      oe_n_ff   <= 1'b1;
      lane_n_ff <= 2'b11;
      dq_ff     <= `SAC_DATA_RST;
      dq_oe_ff  <= 1'b0;
      desel_ff  <= 1'b1;
    end
    else
    begin
      state_ff  <= nxt_state;
      cyc_ff    <= nxt_cyc;
      ready_ff  <= nxt_ready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      addr_ff   <= nxt_addr;
      ce_n_ff   <= nxt_ce_n;
      we_n_ff   <= nxt_we_n;
      oe_n_ff   <= nxt_oe_n;
      lane_n_ff <= nxt_lane_n;
      dq_ff     <= nxt_dq;
      dq_oe_ff  <= nxt_dq_oe;
      desel_ff  <= nxt_desel;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign ready_o               = ready_ff;
  assign rvalid_o              = rvalid_ff;
  assign rdata_o               = rdata_ff;
  assign deselected_o          = desel_ff;
  assign sram_addr_o           = addr_ff;
  assign sram_ce_n_o           = ce_n_ff;
  assign sram_we_n_o           = we_n_ff;
  assign sram_oe_n_o           = oe_n_ff;
  assign upper_lane_enable_n_o = lane_n_ff[1];
  assign lower_lane_enable_n_o = lane_n_ff[0];
  assign sram_dq_o             = dq_ff;
  assign sram_dq_oe_o          = dq_oe_ff;

endmodule

// ===== bench/sac_ctrl_assertions.sv
`timescale 1ns/10ps
module sac_ctrl_checker
#(
  parameter SLOW_GRADE = 0
)
(
  input wire        ref_clk_i,
  input wire        rst_n_i,
  input wire        rvalid_o,
  input wire        deselected_o,
  input wire [17:0] sram_addr_o,
  input wire        sram_ce_n_o,
  input wire        sram_we_n_o,
  input wire        sram_oe_n_o,
  input wire        upper_lane_enable_n_o,
  input wire        lower_lane_enable_n_o,
  input wire [15:0] sram_dq_o,
  input wire        sram_dq_oe_o
);
  localparam int PULSE = SLOW_GRADE ? 10 : 9;
  localparam int GAP   = SLOW_GRADE ? 13 : 11;
  localparam int RV    = SLOW_GRADE ? 16 : 14;
  logic [7:0] we_cnt_ff;
  logic [7:0] gap_cnt_ff;
  wire        off = upper_lane_enable_n_o & lower_lane_enable_n_o;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ****************************************************************
  // Strobe low time and spacing between selects
  // ****************************************************************
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      we_cnt_ff  <= 8'h00;
      gap_cnt_ff <= 8'hff;
    end
    else
    begin
      we_cnt_ff <= sram_we_n_o ? 8'h00 : we_cnt_ff + 8'h01;
      if ($fell(sram_ce_n_o))
        gap_cnt_ff <= 8'h00;
      else if (gap_cnt_ff != 8'hff)
        gap_cnt_ff <= gap_cnt_ff + 8'h01;
    end
  end
  // ****************************************************************
  // Pin relations
  // ****************************************************************
  a_write_start: assert property ($fell(sram_we_n_o) |->
    !sram_ce_n_o && sram_oe_n_o && $past(!sram_ce_n_o))
    else $error("write strobe fell without select");
  a_write_data: assert property (!sram_we_n_o |->
    sram_dq_oe_o && $stable(sram_dq_o) && $stable(sram_addr_o))
    else $error("data or address moved in write");
  a_write_end: assert property ($rose(sram_we_n_o) |->
    sram_dq_oe_o && $stable(sram_dq_o) && $stable(sram_addr_o))
    else $error("data or address not held at write end");
  a_pulse_width: assert property ($rose(sram_we_n_o) |->
    we_cnt_ff >= PULSE)
    else $error("write pulse too short");
  a_read_we_high: assert property (!sram_oe_n_o |->
    sram_we_n_o && !sram_dq_oe_o)
    else $error("strobe or data drive in read");
  a_turn_around: assert property ($rose(sram_oe_n_o) |->
    !sram_dq_oe_o[*5])
    else $error("bus driven before release");
  a_lanes_idle: assert property (sram_ce_n_o |-> off)
    else $error("lanes moved while deselected");
  a_desel_flag: assert property (
    deselected_o == (sram_ce_n_o || off))
    else $error("deselect flag wrong");
  a_read_sample: assert property ($fell(sram_oe_n_o) |->
    ##RV rvalid_o)
    else $error("read data not taken on time");
  a_read_stable: assert property (!sram_oe_n_o &&
    $past(!sram_oe_n_o) |-> $stable(sram_addr_o) && !sram_ce_n_o)
    else $error("read address or select moved");
  a_access_gap: assert property ($fell(sram_ce_n_o) |->
    gap_cnt_ff >= GAP)
    else $error("accesses too close");
  c_write: cover property ($rose(sram_we_n_o) && upper_lane_enable_n_o);
  c_read: cover property (rvalid_o);
  c_empty: cover property (!sram_ce_n_o && off);
endmodule

bind sac_ctrl sac_ctrl_checker #(.SLOW_GRADE(SLOW_GRADE)) chk_i (
  .ref_clk_i, .rst_n_i, .rvalid_o, .deselected_o, .sram_addr_o,
  .sram_ce_n_o, .sram_we_n_o, .sram_oe_n_o, .upper_lane_enable_n_o,
  .lower_lane_enable_n_o, .sram_dq_o, .sram_dq_oe_o);

// ===== bench/sac_sram_model.sv
`timescale 1ns/10ps
module sac_sram_model
#(
  parameter ACC_NS = 45
)
(
  input  wire [17:0] addr_i,
  input  wire        ce_n_i,
  input  wire        we_n_i,
  input  wire        oe_n_i,
  input  wire        upper_lane_enable_n_i,
  input  wire        lower_lane_enable_n_i,
  input  wire        slow_i,
  input  wire [15:0] dq_i,
  output wire [15:0] dq_o
);
  logic [15:0] mem [0:262143];
  logic [15:0] wr_d;
  logic [17:0] wr_a;
  logic [1:0]  wr_l;
  logic        ok = 1'b0;
  wire  [1:0]  lane = ~{upper_lane_enable_n_i, lower_lane_enable_n_i};
  wire         wr_act = !ce_n_i && !we_n_i && (lane != 2'h0);
  wire         rd_on = !ce_n_i && !oe_n_i && we_n_i;
  wire  [15:0] word = mem[addr_i];
  wire  [15:0] msk = {{8{lane[1]}}, {8{lane[0]}}} & {16{rd_on && ok}};
  // Undriven lanes show the inverse word, never a stale match
  assign dq_o = (word & msk) | (~word & ~msk);
  always @*
    if (wr_act)
    begin
      wr_a = addr_i;
      wr_d = dq_i;
      wr_l = lane;
    end
  // Last edge of the overlap commits the data seen before it
  always @(negedge wr_act)
  begin
    if (wr_l[0])
      mem[wr_a][7:0] = wr_d[7:0];
    if (wr_l[1])
      mem[wr_a][15:8] = wr_d[15:8];
  end
  always @(addr_i or rd_on or lane)
  begin
    ok <= #10 1'b0;
    ok <= #(slow_i ? ACC_NS : 10) rd_on;
  end
endmodule

// ===== bench/sac_ctrl_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module sac_ctrl_tb_top;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        req_i = 1'b0;
  logic        req_write_i = 1'b0;
  logic [17:0] req_addr_i = 18'h0_0000;
  logic [15:0] req_wdata_i = 16'h0000;
  logic [1:0]  req_lanes_i = 2'h0;
  logic        slow_i = 1'b0;
  int          miscompares = 0;
  int          tests_run = 0;
  wire         ready_o, rvalid_o, deselected_o, ce_n, we_n, oe_n;
  wire         up_n, lo_n, dq_oe;
  wire  [15:0] rdata_o, dq_out, mem_dq, dq_bus;
  wire  [17:0] addr;
  assign dq_bus = dq_oe ? dq_out : mem_dq;
  logic        req_s = 1'b0;
  wire         rdy_s, rv_s, ce_s, we_s, oe_s, up_s, lo_s, dq_oe_s;
  wire  [15:0] rd_s, dq_out_s, mem_dq_s, bus_s;
  wire  [17:0] addr_s;
  assign bus_s = dq_oe_s ? dq_out_s : mem_dq_s;
  always #2 ref_clk_i = ~ref_clk_i;
  sac_ctrl #(.SLOW_GRADE(0)) sac_ctrl_i (.ref_clk_i, .rst_n_i, .req_i,
    .req_write_i, .req_addr_i, .req_wdata_i, .req_lanes_i, .ready_o,
    .rvalid_o, .rdata_o, .deselected_o, .sram_addr_o(addr),
    .sram_ce_n_o(ce_n), .sram_we_n_o(we_n), .sram_oe_n_o(oe_n),
    .upper_lane_enable_n_o(up_n), .lower_lane_enable_n_o(lo_n),
    .sram_dq_o(dq_out), .sram_dq_oe_o(dq_oe), .sram_dq_i(dq_bus));
  sac_sram_model sac_sram_model_i (.addr_i(addr), .ce_n_i(ce_n),
    .we_n_i(we_n), .oe_n_i(oe_n), .upper_lane_enable_n_i(up_n),
    .lower_lane_enable_n_i(lo_n), .slow_i, .dq_i(dq_bus), .dq_o(mem_dq));
  // Slow grade controller on a memory at its worst-case access time
  sac_ctrl #(.SLOW_GRADE(1)) sac_ctrl_slow_i (.ref_clk_i, .rst_n_i,
    .req_i(req_s), .req_write_i, .req_addr_i, .req_wdata_i, .req_lanes_i,
    .ready_o(rdy_s), .rvalid_o(rv_s), .rdata_o(rd_s), .deselected_o(),
    .sram_addr_o(addr_s), .sram_ce_n_o(ce_s), .sram_we_n_o(we_s),
    .sram_oe_n_o(oe_s), .upper_lane_enable_n_o(up_s),
    .lower_lane_enable_n_o(lo_s), .sram_dq_o(dq_out_s),
    .sram_dq_oe_o(dq_oe_s), .sram_dq_i(bus_s));
  sac_sram_model #(.ACC_NS(55)) sac_sram_model_slow_i (.addr_i(addr_s),
    .ce_n_i(ce_s), .we_n_i(we_s), .oe_n_i(oe_s),
    .upper_lane_enable_n_i(up_s), .lower_lane_enable_n_i(lo_s),
    .slow_i(1'b1), .dq_i(bus_s), .dq_o(mem_dq_s));
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic acc(input logic w, input logic [17:0] a,
    input logic [15:0] d, input logic [1:0] l);
    int n;
    n = 0;
    req_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= a;
    req_wdata_i <= d;
    req_lanes_i <= l;
    do @(posedge ref_clk_i); while (ready_o !== 1'b1 && ++n < 200);
    if (ready_o !== 1'b1)
      miscompares++;
    req_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rd(input logic [17:0] a, input logic [15:0] e);
    int n;
    n = 0;
    acc(1'b0, a, 16'h0000, 2'h3);
    do @(negedge ref_clk_i); while (rvalid_o !== 1'b1 && ++n < 100);
    `CHK(n, 13)
    `CHK(rdata_o, e)
    @(posedge ref_clk_i);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_idle;
    `CHK({ce_n, we_n, oe_n, up_n, lo_n, dq_oe, deselected_o}, 7'h7d)
    `CHK(ready_o, 1'b1)
  endtask
  task automatic t_rw;
    acc(1'b1, 18'h3_ffff, 16'h5aa5, 2'h3);
    acc(1'b1, 18'h0_0000, 16'hc33c, 2'h3);
    rd(18'h3_ffff, 16'h5aa5);
    rd(18'h0_0000, 16'hc33c);
  endtask
  task automatic t_lanes;
    acc(1'b1, 18'h0_0040, 16'h1234, 2'h3);
    acc(1'b1, 18'h0_0040, 16'habcd, 2'h2);
    acc(1'b1, 18'h0_0040, 16'h9876, 2'h1);
    acc(1'b1, 18'h0_0040, 16'hffff, 2'h0);
    `CHK({ce_n, deselected_o}, 2'h1)
    rd(18'h0_0040, 16'hab76);
  endtask
  task automatic t_refused;
    acc(1'b1, 18'h0_0100, 16'h0f0f, 2'h3);
    @(posedge ref_clk_i);
    req_i <= 1'b1;
    req_addr_i <= 18'h0_0000;
    req_wdata_i <= 16'hdead;
    @(posedge ref_clk_i);
    req_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(18'h0_0100, 16'h0f0f);
    rd(18'h0_0000, 16'hc33c);
  endtask
  task automatic t_slow;
    slow_i <= 1'b1;
    rd(18'h3_ffff, 16'h5aa5);
    rd(18'h0_0040, 16'hab76);
    slow_i <= 1'b0;
  endtask
  task automatic t_mid_reset;
    acc(1'b1, 18'h0_0200, 16'h1111, 2'h3);
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    t_idle;
    rd(18'h0_0100, 16'h0f0f);
  endtask
  task automatic t_grade;
    int n;
    n = 0;
    req_s <= 1'b1;
    req_write_i <= 1'b1;
    req_addr_i <= 18'h2_a5a5;
    req_wdata_i <= 16'h3cc3;
    req_lanes_i <= 2'h3;
    do @(posedge ref_clk_i); while (rdy_s !== 1'b1 && ++n < 200);
    if (rdy_s !== 1'b1)
      miscompares++;
    req_s <= 1'b0;
    @(posedge ref_clk_i);
    n = 0;
    req_s <= 1'b1;
    req_write_i <= 1'b0;
    do @(posedge ref_clk_i); while (rdy_s !== 1'b1 && ++n < 200);
    if (rdy_s !== 1'b1)
      miscompares++;
    req_s <= 1'b0;
    n = 0;
    do @(negedge ref_clk_i); while (rv_s !== 1'b1 && ++n < 100);
    `CHK(n, 16)
    `CHK(rd_s, 16'h3cc3)
    @(posedge ref_clk_i);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    t_idle;
    t_rw;
    t_lanes;
    t_refused;
    t_slow;
    t_grade;
    t_mid_reset;
    close_out;
  end
  initial
  begin
    #20000;
    miscompares++;
    close_out;
  end
endmodule
